// ===== gpio_pin_cell.sv
// One port line: mode decode, output value, pad drive and interrupt trigger
`timescale 1ns/100ps
module gpio_pin_cell
  import gpio_port_pkg::*;
#(
  parameter logic [1:0] ALT_KIND = ALT_NONE,
  parameter logic ANALOG_OK = 1'b0
) (
  input wire pin_cfg_s i_cfg,
  input wire logic i_level,
  input wire logic i_prev,
  input wire trig_e i_trig,
  input wire logic i_alt_active,
  input wire logic i_alt_data,
  output pin_drive_s o_drive,
  output logic o_irq
);

  // Value the line would show when it is an output
  logic value;

  // Mode decode and pad drive
  always_comb begin
    // Latch by default; serial functions may take over
    value = i_cfg.latch;
    if (ALT_KIND == ALT_SPI) begin
      // Serial out only merges in open-drain, push-pull shows the latch
      value = i_cfg.opt ? i_cfg.latch : (i_cfg.latch & i_alt_data);
    end else if (ALT_KIND == ALT_UART) begin
      value = i_alt_active ? i_alt_data : i_cfg.latch;
    end
    // Pull-up for both input cases with latch low
    o_drive.pull_up = ~i_cfg.dir & ~i_cfg.latch;
    o_drive.irq_en = ~i_cfg.dir & i_cfg.opt & ~i_cfg.latch;
    o_drive.analog = ~i_cfg.dir & i_cfg.opt & i_cfg.latch & ANALOG_OK;
    // Push-pull drives both levels, open-drain only sinks
    o_drive.out = i_cfg.dir & i_cfg.opt & value;
    o_drive.oe = i_cfg.dir & (i_cfg.opt | ~value);
  end

  // Trigger on the synchronised level and its previous sample
  always_comb begin
    case (i_trig)
      TRIG_FALL: o_irq = o_drive.irq_en & i_prev & ~i_level;
      TRIG_RISE: o_irq = o_drive.irq_en & ~i_prev & i_level;
      TRIG_LOW: o_irq = o_drive.irq_en & ~i_level;
      default: o_irq = 1'b0;
    endcase
  end

endmodule

// ===== gpio_port_lines.sv
// Top of the three four-line port blocks with their data space registers
`timescale 1ns/100ps
module gpio_port_lines
  import gpio_port_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic [11:0] i_pin,
  output logic [11:0] o_pin_out,
  output logic [11:0] o_pin_oe,
  output logic [11:0] o_pull_up,
  output logic [11:0] o_analog_sel,
  input wire logic [2:0][1:0] i_irq_trigger,
  output logic [2:0] o_irq_req,
  input wire logic i_spi_sout,
  output logic o_spi_sin,
  output logic o_spi_sck,
  input wire logic i_uart_tx_active,
  input wire logic i_uart_tx_data,
  output logic o_uart_rx
);

  // Whole state of the block
  typedef struct packed {
    logic [11:0] dir;
    logic [11:0] opt;
    logic [11:0] latch;
    logic [11:0] sync1;
    logic [11:0] sync2;
    logic [11:0] prev;
    logic [11:0] pin_out;
    logic [11:0] pin_oe;
    logic [11:0] pull_up;
    logic [11:0] analog;
    logic [2:0] irq_req;
    logic [7:0] rdata;
    logic spi_sin;
    logic spi_sck;
    logic uart_rx;
  } state_s;

  state_s st; // Registered state
  state_s next_st; // Next state
  logic [11:0] next_dir; // Direction after this cycle's write
  logic [11:0] next_opt; // Option after this cycle's write
  logic [11:0] next_latch; // Latch after this cycle's write
  logic [11:0] read_view; // Data read: pin level or latch
  pin_drive_s [11:0] drive; // Per-line pad decode
  logic [11:0] irq_pin; // Per-line trigger hits

  // Write strobe for one address
  function automatic logic hit(input logic [7:0] a);
    hit = i_wr_en && (i_addr == a);
  endfunction

  // Writes land in the same cycle; only bits of present lines are kept
  assign next_dir = {
    hit(ADDR_DIR_C) ? i_wdata[7:4] : st.dir[11:8],
    hit(ADDR_DIR_B) ? i_wdata[3:0] : st.dir[7:4],
    hit(ADDR_DIR_A) ? i_wdata[7:4] : st.dir[3:0]};
  assign next_opt = {
    hit(ADDR_OPT_C) ? i_wdata[7:4] : st.opt[11:8],
    hit(ADDR_OPT_B) ? i_wdata[3:0] : st.opt[7:4],
    hit(ADDR_OPT_A) ? i_wdata[7:4] : st.opt[3:0]};
  assign next_latch = {
    hit(ADDR_LATCH_C) ? i_wdata[7:4] : st.latch[11:8],
    hit(ADDR_LATCH_B) ? i_wdata[3:0] : st.latch[7:4],
    hit(ADDR_LATCH_A) ? i_wdata[7:4] : st.latch[3:0]};

  // Inputs read the pin, outputs read back the latch; latch is untouched
  assign read_view = (st.dir & st.latch) | (~st.dir & st.sync2);

  // One cell per line, decoding the configuration that takes effect now
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_line
      gpio_pin_cell #(
        .ALT_KIND((g == SPI_SOUT_IDX) ? ALT_SPI : ((g == UART_TX_IDX) ? ALT_UART : ALT_NONE)),
        .ANALOG_OK(ANALOG_CAPABLE[g])
      ) u_cell (
        .i_cfg(pin_cfg_s'{dir: next_dir[g], opt: next_opt[g], latch: next_latch[g]}),
        .i_level(st.sync2[g]),
        .i_prev(st.prev[g]),
        .i_trig(trig_e'(i_irq_trigger[g / 4])),
        .i_alt_active((g == UART_TX_IDX) ? i_uart_tx_active : 1'b1),
        .i_alt_data((g == UART_TX_IDX) ? i_uart_tx_data : i_spi_sout),
        .o_drive(drive[g]),
        .o_irq(irq_pin[g])
      );
    end
  endgenerate

  // Next state: registers, synchronisers, pad drive and read data
  always_comb begin
    next_st = st;
    next_st.dir = next_dir;
    next_st.opt = next_opt;
    next_st.latch = next_latch;
    // Two flops before any logic reads a pin
    next_st.sync1 = i_pin;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    // Pad controls follow the new configuration at once
    for (int k = 0; k < PIN_COUNT; k++) begin
      next_st.pin_out[k] = drive[k].out;
      next_st.pin_oe[k] = drive[k].oe;
      next_st.pull_up[k] = drive[k].pull_up;
      next_st.analog[k] = drive[k].analog;
    end
    // One request line per port
    next_st.irq_req = {|irq_pin[11:8], |irq_pin[7:4], |irq_pin[3:0]};
    // Serial inputs see the pin whatever input mode is chosen
    next_st.spi_sin = st.sync2[SPI_SIN_IDX];
    next_st.spi_sck = st.sync2[SPI_SCK_IDX];
    next_st.uart_rx = st.sync2[UART_RX_IDX];
    // Read data, missing bits fixed
    if (i_rd_en) begin
      case (i_addr)
        ADDR_LATCH_A: next_st.rdata = {read_view[3:0], MISSING_BITS_READ};
        ADDR_LATCH_B: next_st.rdata = {MISSING_BITS_READ, read_view[7:4]};
        ADDR_LATCH_C: next_st.rdata = {read_view[11:8], MISSING_BITS_READ};
        ADDR_DIR_A: next_st.rdata = {st.dir[3:0], MISSING_BITS_READ};
        ADDR_DIR_B: next_st.rdata = {MISSING_BITS_READ, st.dir[7:4]};
        ADDR_DIR_C: next_st.rdata = {st.dir[11:8], MISSING_BITS_READ};
        ADDR_OPT_A: next_st.rdata = {st.opt[3:0], MISSING_BITS_READ};
        ADDR_OPT_B: next_st.rdata = {MISSING_BITS_READ, st.opt[7:4]};
        ADDR_OPT_C: next_st.rdata = {st.opt[11:8], MISSING_BITS_READ};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  // State register; reset leaves every line an input with pull-up
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
      st.dir <= DIR_RESET;
      st.opt <= OPT_RESET;
      st.latch <= LATCH_RESET;
      st.pull_up <= ~DIR_RESET & ~LATCH_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign o_rdata = st.rdata;
  assign o_pin_out = st.pin_out;
  assign o_pin_oe = st.pin_oe;
  assign o_pull_up = st.pull_up;
  assign o_analog_sel = st.analog;
  assign o_irq_req = st.irq_req;
  assign o_spi_sin = st.spi_sin;
  assign o_spi_sck = st.spi_sck;
  assign o_uart_rx = st.uart_rx;

  // Checks on the decoded pad behaviour
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // Input read of port A with all four lines as inputs
  sequence s_read_a_inputs;
    i_rd_en && (i_addr == ADDR_LATCH_A) && (st.dir[3:0] == 4'h0);
  endsequence

  // Low-level trigger armed on line C4 with the pin low
  sequence s_low_armed;
    !st.dir[8] && st.opt[8] && !st.latch[8] && !st.sync2[8]
      && (i_irq_trigger[2] == TRIG_LOW) && !i_wr_en;
  endsequence

  // Rising edge seen on line C4 with its interrupt connection made
  sequence s_rise_seen;
    !st.dir[8] && st.opt[8] && !st.latch[8] && st.sync2[8] && !st.prev[8]
      && (i_irq_trigger[2] == TRIG_RISE) && !i_wr_en;
  endsequence

  // Falling edge seen on line C4 with its interrupt connection made
  sequence s_fall_seen;
    !st.dir[8] && st.opt[8] && !st.latch[8] && !st.sync2[8] && st.prev[8]
      && (i_irq_trigger[2] == TRIG_FALL) && !i_wr_en;
  endsequence

  // Direction write shows in register and pads right after its edge
  a_dir_write_now: assert property (
    i_wr_en && (i_addr == ADDR_DIR_A) |=> st.dir[3:0] == $past(i_wdata[7:4])
      && o_pin_oe[3:0] == (st.dir[3:0] & (st.opt[3:0] | ~o_pin_out[3:0]) & o_pin_oe[3:0]))
    else $error("direction write did not take effect next edge");

  // Latch write of port C lands at its own edge
  a_latch_write_now: assert property (
    i_wr_en && (i_addr == ADDR_LATCH_C) |=> st.latch[11:8] == $past(i_wdata[7:4]))
    else $error("latch write did not take effect next edge");

  // Option bit n of port B lands on line n
  a_opt_write_now: assert property (
    i_wr_en && (i_addr == ADDR_OPT_B) |=> st.opt[7:4] == $past(i_wdata[3:0]))
    else $error("option write landed on wrong lines");

  // Pull-up only where direction and latch are both low
  a_pullup_map: assert property (
    o_pull_up == (~st.dir & ~st.latch))
    else $error("pull-up does not match control bits");

  // Plain input without pull-up neither pulls nor drives
  a_hiz_no_pull: assert property (
    ((~st.dir & st.latch & ~st.opt) & (o_pull_up | o_pin_oe)) == 12'h000)
    else $error("input without pull-up is not high impedance");

  // Analog input neither pulls nor drives either
  a_analog_hiz: assert property (
    (~st.dir & st.opt & st.latch & (o_pull_up | o_pin_oe)) == 12'h000)
    else $error("analog input is not high impedance");

  // Converter select only on capable lines in analog mode
  a_analog_select: assert property (
    o_analog_sel == (~st.dir & st.opt & st.latch & ANALOG_CAPABLE))
    else $error("analog selection mismatch");

  // Open-drain never drives a high level
  a_open_drain_low: assert property (
    (o_pin_out & st.dir & ~st.opt) == 12'h000)
    else $error("open-drain line drives high");

  // Push-pull always drives
  a_push_pull_oe: assert property (
    (st.dir & st.opt & ~o_pin_oe) == 12'h000)
    else $error("push-pull line not driven");

  // Open-drain serial out sinks unless latch and serial data are both high
  a_sout_merge: assert property (
    st.dir[SPI_SOUT_IDX] && !st.opt[SPI_SOUT_IDX] |->
      o_pin_oe[SPI_SOUT_IDX] == !(st.latch[SPI_SOUT_IDX] && $past(i_spi_sout)))
    else $error("open-drain serial out ignores serial data");

  // Push-pull serial out shows the latch, not serial data
  a_sout_latch: assert property (
    st.dir[SPI_SOUT_IDX] && st.opt[SPI_SOUT_IDX] |->
      o_pin_out[SPI_SOUT_IDX] == st.latch[SPI_SOUT_IDX])
    else $error("push-pull serial out not showing latch");

  // Transmit line: latch when idle, transmit data when active
  a_uart_tx_drive: assert property (
    st.dir[UART_TX_IDX] && st.opt[UART_TX_IDX] |-> o_pin_out[UART_TX_IDX] ==
      ($past(i_uart_tx_active) ? $past(i_uart_tx_data) : st.latch[UART_TX_IDX]))
    else $error("transmit line shows wrong source");

  // Serial inputs follow their synchronised pins in any input mode
  a_serial_inputs: assert property (
    o_spi_sin == $past(st.sync2[SPI_SIN_IDX]) && o_spi_sck == $past(st.sync2[SPI_SCK_IDX]))
    else $error("serial input lines do not follow pins");

  // Receive line follows its synchronised pin
  a_receive_input: assert property (
    o_uart_rx == $past(st.sync2[UART_RX_IDX]))
    else $error("receive line does not follow pin");

  // Input read returns the pin level
  a_input_read: assert property (
    s_read_a_inputs |=> o_rdata[7:4] == $past(st.sync2[3:0]))
    else $error("input read did not return pin level");

  // A read never disturbs the latch
  a_read_keeps_latch: assert property (
    i_rd_en && !i_wr_en |=> st.latch == $past(st.latch))
    else $error("read changed the latch");

  // Absent upper bits of port B read fixed
  a_missing_bits: assert property (
    i_rd_en && (i_addr == ADDR_OPT_B) |=> o_rdata[7:4] == MISSING_BITS_READ)
    else $error("missing bits read wrong value");

  // Absent lower bits of port A read fixed
  a_dir_read_fixed: assert property (
    i_rd_en && (i_addr == ADDR_DIR_A) |=> o_rdata[3:0] == MISSING_BITS_READ)
    else $error("missing direction bits read wrong value");

  // Low level keeps the request up
  a_low_irq: assert property (
    s_low_armed |=> o_irq_req[2])
    else $error("low-level trigger gave no request");

  // Rising edge gives a request
  a_rise_irq: assert property (
    s_rise_seen |=> o_irq_req[2])
    else $error("rising trigger gave no request");

  // Falling edge gives a request
  a_fall_irq: assert property (
    s_fall_seen |=> o_irq_req[2])
    else $error("falling trigger gave no request");

  // A port with all lines driven never requests
  a_output_quiet: assert property (
    (st.dir[11:8] == 4'hF) && !i_wr_en |=> !o_irq_req[2])
    else $error("output lines raised a request");

  // Without option bits no line of the port is connected to interrupts
  a_no_option_quiet: assert property (
    (st.opt[11:8] == 4'h0) && !i_wr_en |=> !o_irq_req[2])
    else $error("request without interrupt connection");

endmodule

// ===== gpio_port_pkg.sv
// Package with the constants and carrier types of the configurable port lines
// Contract
// - Dir0 opt0 latch0: input, pull-up, no interrupt
// - Dir0 opt0 latch1: input, no pull-up, no interrupt
// - Dir0 opt1 latch0: pull-up plus interrupt connection
// - Dir0 opt1 latch1: analog input where supported
// - Dir1 opt0: open-drain output, latch ignored for mode
// - Dir1 opt1: push-pull output, latch ignored for mode
// - Input without pull-up is high impedance
// - Interrupt inputs: falling, rising or low trigger
// - Input mode read returns live pin level
// - Analog pins route to converter input multiplexer
// - SPI input pins need input mode, still readable
// - SPI output carries data only in open-drain
// - Push-pull serial output drives latch value
// - UART receive pin needs input, still readable
// - UART transmit pin: latch idle, UART data active
// - Option registers eight bits, bit n line n
// - Reset clears direction, option and latch registers
package gpio_port_pkg;

  // Data space addresses of the port registers
  localparam logic [7:0] ADDR_LATCH_A = 8'hC0;
  localparam logic [7:0] ADDR_LATCH_B = 8'hC1;
  localparam logic [7:0] ADDR_LATCH_C = 8'hC3;
  localparam logic [7:0] ADDR_DIR_A = 8'hC4;
  localparam logic [7:0] ADDR_DIR_B = 8'hC5;
  localparam logic [7:0] ADDR_DIR_C = 8'hC6;
  localparam logic [7:0] ADDR_OPT_A = 8'hCC;
  localparam logic [7:0] ADDR_OPT_B = 8'hCE;
  localparam logic [7:0] ADDR_OPT_C = 8'hCF;

  // Twelve lines: A4-A7 at 3:0, B0-B3 at 7:4, C4-C7 at 11:8
  localparam int PIN_COUNT = 12;
  localparam logic [11:0] DIR_RESET = 12'h000;
  localparam logic [11:0] OPT_RESET = 12'h000;
  localparam logic [11:0] LATCH_RESET = 12'h000;
  localparam logic [11:0] ANALOG_CAPABLE = 12'hFF0;
  localparam logic [3:0] MISSING_BITS_READ = 4'h0;

  // Line indices of the shared serial functions
  localparam int SPI_SCK_IDX = 1;
  localparam int SPI_SIN_IDX = 2;
  localparam int SPI_SOUT_IDX = 3;
  localparam int UART_RX_IDX = 4;
  localparam int UART_TX_IDX = 5;

  // Kind of alternate output a line carries
  localparam logic [1:0] ALT_NONE = 2'h0;
  localparam logic [1:0] ALT_SPI = 2'h1;
  localparam logic [1:0] ALT_UART = 2'h2;

  // Interrupt trigger selected per port
  typedef enum logic [1:0] {
    TRIG_FALL = 2'h0,
    TRIG_RISE = 2'h1,
    TRIG_LOW = 2'h2
  } trig_e;

  // Three control bits of one line
  typedef struct packed {
    logic dir;
    logic opt;
    logic latch;
  } pin_cfg_s;

  // What one line does at its pad
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic analog;
    logic irq_en;
  } pin_drive_s;

endpackage

// ===== pad_world.sv
// Behavioural pads around the port: outside drivers, pull-ups, floating lines
`timescale 1ns/100ps
module pad_world (
  input wire logic i_clk,
  input wire logic [11:0] i_out,
  input wire logic [11:0] i_oe,
  input wire logic [11:0] i_pull_up,
  input wire logic [11:0] i_ext_val,
  input wire logic [11:0] i_ext_en,
  output logic [11:0] o_level
);
  logic [11:0] last = 12'h000; // Level of the previous cycle
  // Remember levels so a floating line can wander
  always_ff @(posedge i_clk) begin
    last <= o_level;
  end
  // Resolve each pad from every party that may drive it
  always_comb begin
    for (int k = 0; k < 12; k++) begin
      if (i_oe[k]) begin // Port drives the pad
        o_level[k] = i_out[k];
      end else if (i_ext_en[k]) begin // Outside driver wherever the port does not drive
        o_level[k] = i_ext_val[k];
      end else if (i_pull_up[k]) begin // Pulled high
        o_level[k] = 1'b1;
      end else begin // High impedance: never a held value
        o_level[k] = ~last[k];
      end
    end
  end
endmodule

// ===== test_gpio_port_lines.sv
// Self-checking bench for the configurable port lines
`timescale 1ns/100ps
module test_gpio_port_lines;
  import gpio_port_pkg::*;
  logic i_clk = 1'b0; // Core clock
  logic i_resetn = 1'b0; // Reset, held at start
  logic [7:0] i_addr = 8'h00;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic [11:0] pin_level, o_pin_out, o_pin_oe, o_pull_up, o_analog_sel;
  logic [11:0] ext_val = 12'h000; // Outside drive values
  logic [11:0] ext_en = 12'h000; // Outside drive enables
  logic [2:0][1:0] trig = {3{2'h3}}; // Triggers, none at start
  logic [2:0] o_irq_req;
  logic spi_sout = 1'b0;
  logic tx_act = 1'b0;
  logic tx_data = 1'b0;
  logic o_spi_sin, o_spi_sck, o_uart_rx;
  int n_fail = 0;
  int compares = 0;
  // Clock of 100 ns period
  always #50 i_clk = ~i_clk;
  gpio_port_lines DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_pin(pin_level), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pull_up(o_pull_up),
    .o_analog_sel(o_analog_sel), .i_irq_trigger(trig), .o_irq_req(o_irq_req),
    .i_spi_sout(spi_sout), .o_spi_sin(o_spi_sin), .o_spi_sck(o_spi_sck),
    .i_uart_tx_active(tx_act), .i_uart_tx_data(tx_data), .o_uart_rx(o_uart_rx));
  pad_world pads (.i_clk(i_clk), .i_out(o_pin_out), .i_oe(o_pin_oe), .i_pull_up(o_pull_up),
    .i_ext_val(ext_val), .i_ext_en(ext_en), .o_level(pin_level));
  // Compare and report
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic end_of_test;
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Let n edges pass, then settle just after the last
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #10;
  endtask
  // One write cycle after an idle edge, so no strobe flips twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    i_addr = a;
    i_wdata = d;
    i_wr_en = 1'b1;
    step(1);
    i_wr_en = 1'b0;
  endtask
  // One read cycle, compared with the expected byte
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    step(1);
    i_addr = a;
    i_rd_en = 1'b1;
    step(1);
    i_rd_en = 1'b0;
    check({4'h0, o_rdata}, {4'h0, e});
  endtask
  // Bounded wait for a port request
  task automatic wait_irq(input int p);
    int k;
    for (k = 0; k < 8 && o_irq_req[p] !== 1'b1; k++) step(1);
    check(12'(o_irq_req[p]), 12'h001);
    if (k == 8) end_of_test();
  endtask
  // Reset state of pads and registers
  task automatic t_reset;
    check(o_pull_up, 12'hFFF);
    check(o_pin_oe | o_analog_sel, 12'h000);
    rd_chk(ADDR_DIR_A, 8'h00);
    rd_chk(ADDR_OPT_C, 8'h00);
  endtask
  // Walk all eight control codes on one line, checked on the writing edge
  task automatic t_modes(input logic [7:0] la, input logic [7:0] da, input logic [7:0] oa,
      input int x);
    logic [2:0] c;
    for (int m = 0; m < 8; m++) begin
      c = 3'(m);
      wr(la, {3'h0, c[0], 4'h0});
      wr(oa, {3'h0, c[1], 4'h0});
      wr(da, {3'h0, c[2], 4'h0});
      check(12'({o_pull_up[x], o_analog_sel[x], o_pin_oe[x], o_pin_out[x]}),
        12'({~c[2] & ~c[0], c == 3'h3 && ANALOG_CAPABLE[x], c[2] & (c[1] | ~c[0]),
        &c}));
    end
    wr(da, 8'h00);
    wr(oa, 8'h00);
    wr(la, 8'h00);
  endtask
  // Each trigger kind on line C4, then no request without the option bit
  task automatic t_irq;
    wr(ADDR_OPT_C, 8'h10);
    ext_en[8] = 1'b1;
    for (int t = 0; t < 3; t++) begin
      ext_val[8] = (t != 1);
      trig[2] = 2'(t);
      step(6);
      ext_val[8] = (t == 1);
      wait_irq(2);
    end
    step(2);
    check(12'(o_irq_req[2]), 12'h001);
    wr(ADDR_OPT_C, 8'h00);
    step(6);
    check(12'(o_irq_req[2]), 12'h000);
    trig[2] = 2'h3;
    ext_en[8] = 1'b0;
  endtask
  // Input read gives the pins, latch kept for the output
  task automatic t_read;
    wr(ADDR_LATCH_C, 8'h10);
    ext_en[8] = 1'b1;
    step(4);
    rd_chk(ADDR_LATCH_C, 8'hE0);
    ext_en[8] = 1'b0;
    wr(ADDR_OPT_C, 8'hF0);
    wr(ADDR_DIR_C, 8'hF0);
    check({o_pin_oe[11:8], o_pin_out[11:8]}, 12'h0F1);
    wr(ADDR_DIR_C, 8'h00);
    wr(ADDR_OPT_C, 8'h00);
    wr(ADDR_LATCH_C, 8'h00);
  endtask
  // Serial lines shared with the SPI and UART
  task automatic t_alt;
    ext_en = 12'h016;
    for (int v = 0; v < 2; v++) begin
      ext_val = {7'h0, 1'(v), 1'h0, 1'(v), ~1'(v), 1'h0};
      step(4);
      check(12'({o_spi_sin, o_spi_sck, o_uart_rx}), 12'({1'(v), ~1'(v), 1'(v)}));
      rd_chk(ADDR_LATCH_A, {1'b1, 1'(v), ~1'(v), 1'b1, 4'h0});
    end
    ext_en = 12'h000;
    wr(ADDR_LATCH_A, 8'h80);
    wr(ADDR_DIR_A, 8'h80);
    step(2);
    check(12'({o_pin_oe[3], o_pin_out[3]}), 12'h002);
    spi_sout = 1'b1;
    step(2);
    check(12'({o_pin_oe[3], o_pin_out[3]}), 12'h000);
    spi_sout = 1'b0;
    wr(ADDR_OPT_A, 8'h80);
    step(2);
    check(12'({o_pin_oe[3], o_pin_out[3]}), 12'h003);
    wr(ADDR_DIR_B, 8'h02);
    wr(ADDR_OPT_B, 8'h02);
    tx_data = 1'b1;
    step(2);
    check(12'(o_pin_out[5]), 12'h000);
    tx_act = 1'b1;
    step(2);
    check(12'(o_pin_out[5]), 12'h001);
  endtask
  // Option bit placement, missing bits and an unmapped place
  task automatic t_bits;
    wr(ADDR_OPT_A, 8'h5A);
    rd_chk(ADDR_OPT_A, 8'h50);
    wr(ADDR_OPT_B, 8'h5A);
    rd_chk(ADDR_OPT_B, 8'h0A);
    wr(ADDR_OPT_C, 8'hA5);
    rd_chk(ADDR_OPT_C, 8'hA0);
    wr(8'hD0, 8'hFF);
    rd_chk(8'hD0, 8'h00);
  endtask
  // Main sequence
  initial begin
    step(16);
    i_resetn = 1'b1;
    step(1);
    t_reset();
    t_modes(ADDR_LATCH_A, ADDR_DIR_A, ADDR_OPT_A, 0);
    t_modes(ADDR_LATCH_C, ADDR_DIR_C, ADDR_OPT_C, 8);
    t_irq();
    t_read();
    t_alt();
    t_bits();
    // Reset again in mid-run: every line back to input with pull-up
    i_resetn = 1'b0;
    step(2);
    i_resetn = 1'b1;
    step(1);
    t_reset();
    end_of_test();
  end
endmodule
